// [logic/vpo_pkg.sv]
// Purpose: shared constants for the valve position output block
// Assumes: positions and percentages in signed tenths of a percent
// Notes: times are in nanoseconds, milliseconds, seconds or minutes, counts derived below
package vpo_pkg;
	// Data widths
	localparam int POS_W = 12;
	localparam int MT_W = 10;
	// Control action codes
	localparam logic [3:0] CA_PID_REV = 4'h1;
	localparam logic [3:0] CA_POS_REV = 4'h5;
	// Position scale in tenths of a percent
	localparam logic signed [12:0] POS_CLOSED = 13'sh0000;
	localparam logic signed [12:0] POS_OPEN = 13'sh03E8;
	localparam logic [21:0] SPAN_TENTHS = 22'h0003E8;
	// Setting defaults, for the party driving the config ports
	localparam logic signed [11:0] STOP_POS_DEF = 12'sh000;
	localparam logic signed [11:0] LIM_HI_DEF = 12'sh41A;
	localparam logic signed [11:0] LIM_LO_DEF = -12'sh032;
	localparam logic signed [11:0] AT_ON_DEF = 12'sh41A;
	localparam logic signed [11:0] AT_OFF_DEF = -12'sh41A;
	localparam logic [7:0] NZ_DEF = 8'h14;
	localparam logic [7:0] GAP_DEF = 8'h0A;
	localparam logic [10:0] INTEG_DEF = 11'h5DC;
	// Motor travel time range and reset value, seconds
	localparam logic [MT_W-1:0] MT_DEF = 10'h00A;
	localparam logic [MT_W-1:0] MT_MIN = 10'h005;
	localparam logic [MT_W-1:0] MT_MAX = 10'h3E8;
	// Stop-action codes
	localparam logic [1:0] STOP_BOTH_OFF = 2'h0;
	localparam logic [1:0] STOP_CLOSE_ON = 2'h1;
	localparam logic [1:0] STOP_OPEN_ON = 2'h2;
	// Clock and tick timing
	localparam int CLK_NS = 5;
	localparam int TICK_MS = 1;
	localparam int TICK_CYC = TICK_MS * 1000000 / CLK_NS;
	localparam int MS_PER_SEC = 1000 / TICK_MS;
	// Front panel hold times
	localparam int ENG_HOLD_S = 2;
	localparam int CAL_HOLD_S = 5;
	localparam int IDLE_MIN = 1;
	localparam int ENG_HOLD_TK = ENG_HOLD_S * 1000 / TICK_MS;
	localparam int CAL_HOLD_TK = CAL_HOLD_S * 1000 / TICK_MS;
	localparam int IDLE_TK = IDLE_MIN * 60000 / TICK_MS;
	// Calibration states
	typedef enum logic [1:0] {CAL_IDLE, CAL_CLOSE, CAL_OPEN} vpo_cal_t;
endpackage

// [logic/vpo_hold_timer.sv]
// Purpose: one-shot pulse after a level has held for a tick count
// Assumes: tick_en is a one-cycle pulse on sys_clk
// Notes: fires once per hold; level must drop to re-arm
module vpo_hold_timer #(
	parameter int HOLD_TK = 2000
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Timing
	input wire logic tick_en,
	input wire logic level,
	// Result
	output logic fire
);
	typedef struct packed {
		logic [16:0] cnt;
		logic done;
		logic fire;
	} vpo_ht_t;
	vpo_ht_t st_r, st_nxt;

	// Count while held, pulse on reaching the hold time
	always_comb begin
		st_nxt = st_r;
		st_nxt.fire = 1'b0;
		if (!level) begin
			st_nxt.cnt = 17'h00000;
			st_nxt.done = 1'b0;
		end else if (tick_en && !st_r.done) begin
			st_nxt.cnt = st_r.cnt + 17'h00001;
			if (st_r.cnt == 17'(HOLD_TK - 1)) begin
				st_nxt.done = 1'b1;
				st_nxt.fire = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign fire = st_r.fire;
endmodule

// [logic/vpo_valve_ctrl.sv]
// Purpose: open/close motor drive for a position proportioning valve
// Assumes: mv and limits in signed tenths of a percent, feedback a raw unsigned 12-bit pot code
// Notes: keys are raw pins and pass a three-stage synchroniser
module vpo_valve_ctrl #(
	parameter int TICK_CYC = vpo_pkg::TICK_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Mode and status from the controller
	input wire logic [3:0] control_action,
	input wire logic run_mode,
	input wire logic manual_mode,
	input wire logic self_tuning_run,
	input wire logic signed [11:0] first_manipulated_output,
	// Feedback input
	input wire logic fbr_fitted,
	input wire logic [11:0] feedback_resistance_input,
	input wire logic fbr_input_error,
	// Settings
	input wire logic signed [11:0] stop_position,
	input wire logic signed [11:0] out_limit_high,
	input wire logic signed [11:0] out_limit_low,
	input wire logic signed [11:0] at_on_value,
	input wire logic signed [11:0] at_off_value,
	input wire logic [7:0] neutral_zone,
	input wire logic [7:0] diff_gap,
	input wire logic fbr_error_action,
	input wire logic [1:0] stop_action,
	input wire logic saturation_hold,
	input wire logic [10:0] integ_limit,
	input wire logic [9:0] motor_time_set,
	input wire logic motor_time_load,
	// Front panel
	input wire logic [3:0] key_pins,
	input wire logic on_monitor_screen,
	input wire logic on_cal_prep_screen,
	// Motor drive
	output logic open_side_output,
	output logic close_side_output,
	// Status
	output logic pos_pid_active,
	output logic fbr_fault_flag,
	output logic signed [11:0] valve_position,
	output logic [9:0] motor_time,
	output logic cal_busy,
	output logic cal_done,
	output logic eng_mode_enter,
	output logic return_to_monitor
);
	typedef struct packed {
		logic [3:0] k1, k2, k3, keys;
		logic [17:0] ms_cnt;
		logic ms_tick;
		logic [9:0] sub_cnt;
		logic sec_tick;
		logic open_on, close_on;
		logic dir_open, inhibit;
		logic [20:0] integ_ms;
		logic [9:0] est_div;
		logic signed [11:0] est_pos;
		logic [9:0] mtime;
		logic fault;
		vpo_pkg::vpo_cal_t cal;
		logic [11:0] cal_lo, cal_hi, cal_last;
		logic [10:0] cal_sec;
		logic cal_done;
	} vpo_st_t;
	vpo_st_t st_r, st_nxt;

	logic key_up, key_down, key_shift, key_set;
	logic eng_fire, cal_fire, idle_fire;
	logic signed [11:0] fb_pos, pos_src, cmd, lo_b, hi_b;
	logic signed [12:0] dev, on_th, off_th;
	logic [21:0] fb_num;
	logic [11:0] fb_span;
	logic [20:0] integ_lim_ms;
	logic fb_ok, want_open, want_close, servo;

	assign key_up = st_r.keys[0];
	assign key_down = st_r.keys[1];
	assign key_shift = st_r.keys[2];
	assign key_set = st_r.keys[3];

	// Panel hold timers share the millisecond tick
	vpo_hold_timer #(.HOLD_TK(vpo_pkg::ENG_HOLD_TK)) u_eng (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.tick_en(st_r.ms_tick),
		.level(key_shift && key_set && on_monitor_screen),
		.fire(eng_fire)
	);
	vpo_hold_timer #(.HOLD_TK(vpo_pkg::CAL_HOLD_TK)) u_cal (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.tick_en(st_r.ms_tick),
		.level(key_shift && on_cal_prep_screen && fbr_fitted),
		.fire(cal_fire)
	);
	vpo_hold_timer #(.HOLD_TK(vpo_pkg::IDLE_TK)) u_idle (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.tick_en(st_r.ms_tick),
		.level(st_r.keys == 4'h0 && st_r.cal == vpo_pkg::CAL_IDLE),
		.fire(idle_fire)
	);

	// Feedback scaled onto 0..100 % of the calibrated span
	always_comb begin
		fb_span = st_r.cal_hi - st_r.cal_lo;
		if (fb_span == 12'h000)
			fb_span = 12'h001;
		if (feedback_resistance_input <= st_r.cal_lo)
			fb_num = 22'h000000;
		else
			fb_num = 22'(feedback_resistance_input - st_r.cal_lo)
				* vpo_pkg::SPAN_TENTHS;
		fb_pos = 12'(fb_num / 22'(fb_span));
	end

	// Command selection, limits and deviation
	always_comb begin
		fb_ok = fbr_fitted && !st_r.fault;
		pos_src = fb_ok ? fb_pos : st_r.est_pos;
		// Stop position only reachable while feedback is trusted
		cmd = run_mode ? first_manipulated_output : stop_position;
		lo_b = out_limit_low;
		hi_b = out_limit_high;
		if (self_tuning_run && run_mode) begin
			if (at_off_value > lo_b)
				lo_b = at_off_value;
			if (at_on_value < hi_b)
				hi_b = at_on_value;
		end
		if (fbr_fitted) begin
			if (cmd > hi_b)
				cmd = hi_b;
			if (cmd < lo_b)
				cmd = lo_b;
		end
		dev = 13'(cmd) - 13'(pos_src);
		on_th = 13'(neutral_zone >> 1);
		off_th = on_th - 13'(diff_gap);
		if (off_th < 13'sh0000)
			off_th = 13'sh0000;
		integ_lim_ms = 21'(integ_limit) * 21'(st_r.mtime);
	end

	// Hysteretic servo request, one direction at a time
	always_comb begin
		want_open = st_r.open_on ? (dev > off_th) : (dev > on_th);
		want_close = st_r.close_on ? (dev < -off_th) : (dev < -on_th);
		if (fb_ok && !saturation_hold) begin
			if (13'(pos_src) >= vpo_pkg::POS_OPEN)
				want_open = 1'b0;
			if (13'(pos_src) <= vpo_pkg::POS_CLOSED)
				want_close = 1'b0;
		end
	end

	// Next state of the whole block
	always_comb begin
		st_nxt = st_r;
		servo = 1'b0;
		// Key synchroniser, change taken when stages two and three agree
		st_nxt.k1 = key_pins;
		st_nxt.k2 = st_r.k1;
		st_nxt.k3 = st_r.k2;
		for (int i = 0; i < 4; i++) begin
			if (st_r.k2[i] == st_r.k3[i])
				st_nxt.keys[i] = st_r.k3[i];
		end
		// Millisecond and second ticks from one divider chain
		st_nxt.ms_tick = 1'b0;
		st_nxt.sec_tick = 1'b0;
		if (st_r.ms_cnt == 18'(TICK_CYC - 1)) begin
			st_nxt.ms_cnt = 18'h00000;
			st_nxt.ms_tick = 1'b1;
		end else begin
			st_nxt.ms_cnt = st_r.ms_cnt + 18'h00001;
		end
		if (st_r.ms_tick) begin
			if (st_r.sub_cnt == 10'(vpo_pkg::MS_PER_SEC - 1)) begin
				st_nxt.sub_cnt = 10'h000;
				st_nxt.sec_tick = 1'b1;
			end else begin
				st_nxt.sub_cnt = st_r.sub_cnt + 10'h001;
			end
		end
		st_nxt.fault = fbr_fitted && fbr_input_error;
		// Manual travel time entry, out-of-range values ignored
		if (motor_time_load && motor_time_set >= vpo_pkg::MT_MIN
			&& motor_time_set <= vpo_pkg::MT_MAX)
			st_nxt.mtime = motor_time_set;
		// Output decision, in priority order
		st_nxt.open_on = 1'b0;
		st_nxt.close_on = 1'b0;
		st_nxt.cal_done = 1'b0;
		if (control_action != vpo_pkg::CA_POS_REV) begin
			st_nxt.cal = vpo_pkg::CAL_IDLE;
		end else if (st_r.cal != vpo_pkg::CAL_IDLE) begin
			st_nxt.close_on = (st_r.cal == vpo_pkg::CAL_CLOSE);
			st_nxt.open_on = (st_r.cal == vpo_pkg::CAL_OPEN);
		end else if ((st_r.fault && !fbr_error_action)
			|| (!run_mode && !fb_ok)) begin
			// Fixed stop pattern; also the error action when chosen
			st_nxt.close_on = (stop_action == vpo_pkg::STOP_CLOSE_ON);
			st_nxt.open_on = (stop_action == vpo_pkg::STOP_OPEN_ON);
		end else if (manual_mode && run_mode && !fbr_fitted) begin
			// Up wins if both keys held, keeping outputs exclusive
			st_nxt.open_on = key_up;
			st_nxt.close_on = key_down && !key_up;
		end else begin
			servo = 1'b1;
			st_nxt.open_on = want_open;
			st_nxt.close_on = want_close && !want_open;
		end
		// Integrated limiter, no feedback only; restart on reversal
		if ((st_nxt.open_on && !st_r.dir_open)
			|| (st_nxt.close_on && st_r.dir_open)) begin
			st_nxt.dir_open = st_nxt.open_on;
			st_nxt.integ_ms = 21'h000000;
			st_nxt.inhibit = 1'b0;
		end else if (servo && !fbr_fitted && integ_limit != 11'h000) begin
			if (st_r.inhibit) begin
				st_nxt.open_on = 1'b0;
				st_nxt.close_on = 1'b0;
			end else if ((st_r.open_on || st_r.close_on) && st_r.ms_tick) begin
				st_nxt.integ_ms = st_r.integ_ms + 21'h000001;
				if (st_nxt.integ_ms >= integ_lim_ms * 21'(vpo_pkg::MS_PER_SEC / 1000))
					st_nxt.inhibit = 1'b1;
			end
		end
		// Estimated position: one tenth per travel-time milliseconds
		if (st_r.ms_tick && (st_r.open_on || st_r.close_on)) begin
			if (st_r.est_div >= st_r.mtime - 10'h001) begin
				st_nxt.est_div = 10'h000;
				if (st_r.open_on && 13'(st_r.est_pos) < vpo_pkg::POS_OPEN)
					st_nxt.est_pos = st_r.est_pos + 12'sh001;
				if (st_r.close_on && 13'(st_r.est_pos) > vpo_pkg::POS_CLOSED)
					st_nxt.est_pos = st_r.est_pos - 12'sh001;
			end else begin
				st_nxt.est_div = st_r.est_div + 10'h001;
			end
		end
		// Calibration: close to the end stop, then time the full opening
		case (st_r.cal)
			vpo_pkg::CAL_IDLE: begin
				if (cal_fire && fbr_fitted
					&& control_action == vpo_pkg::CA_POS_REV) begin
					st_nxt.cal = vpo_pkg::CAL_CLOSE;
					st_nxt.cal_sec = 11'h000;
					st_nxt.cal_last = feedback_resistance_input;
				end
			end
			vpo_pkg::CAL_CLOSE: begin
				if (st_r.sec_tick) begin
					st_nxt.cal_last = feedback_resistance_input;
					st_nxt.cal_sec = st_r.cal_sec + 11'h001;
					// End stop reached once a full second brings no change
					if (st_r.cal_sec != 11'h000
						&& feedback_resistance_input == st_r.cal_last) begin
						st_nxt.cal_lo = feedback_resistance_input;
						st_nxt.cal = vpo_pkg::CAL_OPEN;
						st_nxt.cal_sec = 11'h000;
					end
				end
			end
			vpo_pkg::CAL_OPEN: begin
				if (st_r.sec_tick) begin
					st_nxt.cal_last = feedback_resistance_input;
					st_nxt.cal_sec = st_r.cal_sec + 11'h001;
					if (st_r.cal_sec != 11'h000
						&& feedback_resistance_input == st_r.cal_last) begin
						st_nxt.cal_hi = feedback_resistance_input;
						st_nxt.cal = vpo_pkg::CAL_IDLE;
						st_nxt.cal_done = 1'b1;
						// Last second was the settle check, not travel
						if (st_r.cal_sec - 11'h001 >= 11'(vpo_pkg::MT_MIN)
							&& st_r.cal_sec - 11'h001 <= 11'(vpo_pkg::MT_MAX))
							st_nxt.mtime = 10'(st_r.cal_sec - 11'h001);
					end else if (st_r.cal_sec > 11'(vpo_pkg::MT_MAX)) begin
						// Motor never settled: give up, keep old cal_hi and travel time
						st_nxt.cal = vpo_pkg::CAL_IDLE;
						st_nxt.cal_done = 1'b1;
					end
				end
			end
			default: st_nxt.cal = vpo_pkg::CAL_IDLE;
		endcase
	end

	// Single state register; reset leaves the valve assumed closed
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_r <= '0;
			st_r.mtime <= vpo_pkg::MT_DEF;
			st_r.cal_hi <= 12'hFFF;
			st_r.cal <= vpo_pkg::CAL_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs from flip-flops except pos_pid_active, valve_position and cal_busy, which are combinational
	assign open_side_output = st_r.open_on;
	assign close_side_output = st_r.close_on;
	assign pos_pid_active = (control_action == vpo_pkg::CA_POS_REV);
	assign fbr_fault_flag = st_r.fault;
	assign valve_position = fb_ok ? fb_pos : st_r.est_pos;
	assign motor_time = st_r.mtime;
	assign cal_busy = (st_r.cal != vpo_pkg::CAL_IDLE);
	assign cal_done = st_r.cal_done;
	assign eng_mode_enter = eng_fire;
	assign return_to_monitor = idle_fire;
endmodule

// [bench/vpo_valve_monitor.sv]
// Purpose: port checker for the valve output block
// Assumes: one clock, synchronous active-low reset
// Notes: servo checks only where feedback is healthy
module vpo_valve_monitor (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Inputs watched
	input wire logic [3:0] control_action,
	input wire logic run_mode,
	input wire logic manual_mode,
	input wire logic self_tuning_run,
	input wire logic signed [11:0] first_manipulated_output,
	input wire logic fbr_fitted,
	input wire logic fbr_input_error,
	input wire logic signed [11:0] out_limit_high,
	input wire logic signed [11:0] out_limit_low,
	input wire logic [7:0] neutral_zone,
	input wire logic fbr_error_action,
	input wire logic [1:0] stop_action,
	input wire logic [9:0] motor_time_set,
	input wire logic motor_time_load,
	input wire logic [3:0] key_pins,
	// Outputs watched
	input wire logic open_side_output,
	input wire logic close_side_output,
	input wire logic pos_pid_active,
	input wire logic fbr_fault_flag,
	input wire logic signed [11:0] valve_position,
	input wire logic [9:0] motor_time,
	input wire logic cal_busy,
	input wire logic cal_done
);
	logic servo, zone_out, so_open, so_close, ld_ok, flt, man;
	logic signed [13:0] cmd, dev, half;
	// Clamped command and deviation, as the servo sees them
	always_comb begin
		cmd = first_manipulated_output;
		if (cmd > out_limit_high)
			cmd = out_limit_high;
		if (cmd < out_limit_low)
			cmd = out_limit_low;
		dev = cmd - valve_position;
		half = {7'h00, neutral_zone[7:1]};
		zone_out = dev > half;
		servo = pos_pid_active && run_mode && !manual_mode && fbr_fitted
			&& !self_tuning_run && !fbr_input_error && !cal_busy;
		so_open = stop_action == 2'h2;
		so_close = stop_action == 2'h1;
		ld_ok = motor_time_load && motor_time_set >= vpo_pkg::MT_MIN
			&& motor_time_set <= vpo_pkg::MT_MAX;
		flt = fbr_fitted && fbr_input_error;
		man = pos_pid_active && run_mode && manual_mode && !fbr_fitted;
	end
	default clocking dc @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	both_off_a: assert property (
		!(open_side_output && close_side_output))
		else $error("open and close both on");
	act_code_a: assert property (
		pos_pid_active == (control_action == vpo_pkg::CA_POS_REV))
		else $error("enable does not follow action code");
	disabled_off_a: assert property (
		control_action != vpo_pkg::CA_POS_REV
		|=> !open_side_output && !close_side_output)
		else $error("output while not enabled");
	fault_flag_a: assert property (
		1'b1 |=> fbr_fault_flag == $past(flt))
		else $error("fault flag wrong");
	time_load_a: assert property (
		ld_ok && !cal_busy |=> motor_time == $past(motor_time_set))
		else $error("travel time not loaded");
	time_keep_a: assert property (
		motor_time_load && !ld_ok && !cal_busy |=> $stable(motor_time))
		else $error("bad travel time taken");
	stop_code_a: assert property (
		pos_pid_active && !run_mode && !fbr_fitted && !cal_busy
		&& stop_action != 2'h3 |=> open_side_output == $past(so_open)
		&& close_side_output == $past(so_close))
		else $error("stop pattern wrong");
	fault_stop_a: assert property (
		pos_pid_active && flt && fbr_fault_flag && !fbr_error_action
		&& !cal_busy && stop_action != 2'h3
		|=> open_side_output == $past(so_open)
		&& close_side_output == $past(so_close))
		else $error("fault pattern wrong");
	manual_up_a: assert property (
		(man && key_pins[0]) [*5] |=> open_side_output && !close_side_output)
		else $error("up key not driving open");
	manual_off_a: assert property (
		(man && key_pins[1:0] == 2'h0) [*5]
		|=> !open_side_output && !close_side_output)
		else $error("output without key");
	zone_open_a: assert property (
		$rose(open_side_output) && $past(servo) |-> $past(zone_out))
		else $error("open inside neutral zone");
	gap_hold_a: assert property (
		open_side_output && servo && zone_out
		&& valve_position < vpo_pkg::POS_OPEN |=> open_side_output)
		else $error("open dropped outside zone");
	// Main scenarios reached
	cover property ($rose(cal_done));
	cover property ($fell(open_side_output) && !fbr_fitted);
	cover property ($rose(close_side_output) && servo);
endmodule

bind vpo_valve_ctrl vpo_valve_monitor mon (.*);

// [bench/vpo_valve_model.sv]
// Purpose: motor-driven valve with a position pot
// Assumes: drive outputs power the motor directly
// Notes: code 0 is closed, 12'hFFF open; ends are hard stops
module vpo_valve_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Motor drive and speed
	input wire logic open_side_output,
	input wire logic close_side_output,
	input wire logic slow,
	// Pot reading
	output logic [11:0] feedback_resistance_input
);
	logic [1:0] div_r;
	// One code a step; slow motor steps every fourth cycle
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			feedback_resistance_input <= 12'h800;
			div_r <= 2'h0;
		end else begin
			div_r <= div_r + 2'h1;
			if (!slow || div_r == 2'h3) begin
				if (open_side_output && feedback_resistance_input != 12'hFFF)
					feedback_resistance_input <= feedback_resistance_input + 12'h1;
				else if (close_side_output && feedback_resistance_input != 12'h0)
					feedback_resistance_input <= feedback_resistance_input - 12'h1;
			end
		end
	end
endmodule

// [bench/tb.sv]
// Purpose: self-checking bench for the valve output block
// Assumes: short tick so panel holds fit in the run
// Notes: position checks allow the neutral zone as slack
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
	n_fail++; $display("MISMATCH %s exp %0d got %0d", nm, e, g); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TK = 2;
	logic sys_clk = 0, rst_n = 0, run_mode = 1, manual_mode = 0, tune = 0;
	logic [3:0] control_action = vpo_pkg::CA_POS_REV, key_pins = 4'h0;
	logic signed [11:0] mv = 12'sh000, stop_pos = vpo_pkg::STOP_POS_DEF;
	logic signed [11:0] lim_hi = vpo_pkg::LIM_HI_DEF, at_on = 12'sh41A;
	logic fitted = 1, err = 0, err_act = 0, sat = 0, mt_load = 0, slow = 0;
	logic mon_scr = 0, prep_scr = 0;
	logic [1:0] stop_act = 2'h0;
	logic [10:0] integ = 11'h00A;
	logic [9:0] mt_set = 10'h000, motor_time;
	logic [11:0] fb;
	logic open_o, close_o, act, flag, busy, done, eng, ret;
	logic signed [11:0] vpos;
	int n_fail = 0, check_count = 0, n;
	vpo_valve_ctrl #(.TICK_CYC(TK)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
		.control_action(control_action), .run_mode(run_mode),
		.manual_mode(manual_mode), .self_tuning_run(tune),
		.first_manipulated_output(mv), .fbr_fitted(fitted),
		.feedback_resistance_input(fb), .fbr_input_error(err),
		.stop_position(stop_pos), .out_limit_high(lim_hi),
		.out_limit_low(vpo_pkg::LIM_LO_DEF), .at_on_value(at_on),
		.at_off_value(vpo_pkg::AT_OFF_DEF), .neutral_zone(vpo_pkg::NZ_DEF),
		.diff_gap(vpo_pkg::GAP_DEF), .fbr_error_action(err_act),
		.stop_action(stop_act), .saturation_hold(sat), .integ_limit(integ),
		.motor_time_set(mt_set), .motor_time_load(mt_load),
		.key_pins(key_pins), .on_monitor_screen(mon_scr),
		.on_cal_prep_screen(prep_scr), .open_side_output(open_o),
		.close_side_output(close_o), .pos_pid_active(act),
		.fbr_fault_flag(flag), .valve_position(vpos), .motor_time(motor_time),
		.cal_busy(busy), .cal_done(done), .eng_mode_enter(eng),
		.return_to_monitor(ret));
	vpo_valve_model valve (.sys_clk(sys_clk), .rst_n(rst_n),
		.open_side_output(open_o), .close_side_output(close_o), .slow(slow),
		.feedback_resistance_input(fb));
	// 200 MHz clock
	always #2.5 sys_clk = ~sys_clk;
	// Expected settle point: command clamped to the upper limit
	function automatic logic near(input int t, input int hi);
		int c;
		c = (t > hi) ? hi : t;
		return (vpos - c <= 20) && (c - vpos <= 20);
	endfunction
	// Output picked by number, so one bounded wait serves them all
	function automatic logic pick(input int w);
		case (w)
			0: return open_o;
			1: return close_o;
			2: return busy;
			3: return done;
			default: return eng;
		endcase
	endfunction
	task automatic wait_lvl(input int w, input logic v, output int k);
		k = 0;
		while (pick(w) !== v && k < 40000) begin
			@(posedge sys_clk);
			k++;
		end
	endtask
	// Wait until the motor has been idle for a while, bounded
	task automatic settle;
		int q;
		q = 0;
		for (int i = 0; i < 30000 && q < 50; i++) begin
			@(posedge sys_clk);
			q = (open_o | close_o) ? 0 : q + 1;
		end
	endtask
	task automatic stop_codes;
		for (int k = 0; k < 3; k++) begin
			stop_act <= k[1:0];
			repeat (3) @(posedge sys_clk);
			`CHK("stop_open", k == 2, open_o)
			`CHK("stop_close", k == 1, close_o)
		end
		stop_act <= 2'h0;
	endtask
	task automatic calibrate;
		key_pins <= 4'h4;
		wait_lvl(2, 1'b1, n);
		`CHK("cal_hold", 1'b1, n > 9990 && n < 10012)
		key_pins <= 4'h0;
		wait_lvl(3, 1'b1, n);
		`CHK("cal_done", 1'b1, n < 40000)
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Watchdog sized for the full sequence
	initial begin
		repeat (100000) @(posedge sys_clk);
		n_fail++;
		stop_test();
	end
	// Main sequence
	initial begin
		void'($urandom(32'h3d1b0327));
		repeat (4) @(posedge sys_clk);
		rst_n <= 1;
		@(posedge sys_clk);
		`CHK("mt_reset", vpo_pkg::MT_DEF, motor_time)
		for (int i = 0; i < 4; i++) begin
			mv <= 12'(20 + $urandom % 960);
			@(posedge sys_clk);
			settle();
			`CHK("servo", 1'b1, near(mv, 1050))
		end
		lim_hi <= 12'sh258;
		mv <= 12'sh384;
		settle();
		`CHK("clamp", 1'b1, near(600, 1050))
		lim_hi <= vpo_pkg::LIM_HI_DEF;
		tune <= 1;
		at_on <= 12'sh190;
		settle();
		`CHK("tune", 1'b1, near(400, 1050))
		tune <= 0;
		mv <= 12'sh41A;
		settle();
		`CHK("sat_off", 1'b0, open_o)
		sat <= 1;
		repeat (5) @(posedge sys_clk);
		`CHK("sat_on", 1'b1, open_o)
		sat <= 0;
		run_mode <= 0;
		stop_pos <= 12'sh12C;
		settle();
		`CHK("stop_pos", 1'b1, near(300, 1050))
		err <= 1;
		stop_codes();
		`CHK("flag", 1'b1, flag)
		// Error action 1 keeps control running on the estimate
		err_act <= 1;
		run_mode <= 1;
		repeat (3) @(posedge sys_clk);
		`CHK("err_cont", 1'b1, open_o)
		err_act <= 0;
		run_mode <= 0;
		err <= 0;
		fitted <= 0;
		stop_codes();
		run_mode <= 1;
		manual_mode <= 1;
		key_pins <= 4'h1;
		repeat (6) @(posedge sys_clk);
		`CHK("man_up", 1'b1, open_o)
		key_pins <= 4'h2;
		repeat (6) @(posedge sys_clk);
		`CHK("man_dn", 1'b1, close_o)
		key_pins <= 4'h0;
		manual_mode <= 0;
		mt_set <= 10'h00C;
		mt_load <= 1;
		@(posedge sys_clk);
		mt_set <= 10'h3E9;
		@(posedge sys_clk);
		mt_load <= 0;
		@(posedge sys_clk);
		`CHK("mt_load", 10'h00C, motor_time)
		// Full-scale commands: the estimate can never sit inside the zone
		for (int i = 0; i < 3; i++) begin
			mv <= (i == 1) ? 12'sh41A : -12'sh032;
			wait_lvl(i == 1 ? 0 : 1, 1'b1, n);
			wait_lvl(i == 1 ? 0 : 1, 1'b0, n);
			`CHK("limiter", 1'b1, n > 234 && n < 246)
		end
		mon_scr <= 1;
		key_pins <= 4'hC;
		wait_lvl(4, 1'b1, n);
		`CHK("eng", 1'b1, n > 3990 && n < 4012)
		`CHK("idle_ret", 1'b0, ret)
		key_pins <= 4'h0;
		mon_scr <= 0;
		fitted <= 1;
		// Operator stops control before calibrating
		run_mode <= 0;
		prep_scr <= 1;
		calibrate();
		`CHK("mt_short", 10'h00C, motor_time)
		slow <= 1;
		calibrate();
		`CHK("mt_cal", 1'b1, motor_time inside {[6:9]})
		`CHK("span", 12'sh3E8, vpos)
		stop_test();
	end
endmodule
